// [adc_conversion_host_control_test.sv]
// Self-checking testbench of the converter control block
`timescale 1ns/10ps
module adc_conversion_host_control_test;
  localparam int DIV = 8;
  logic        sys_clk;
  logic        resetn;
  logic        comp_in;
  logic        conv_clk_in;
  logic        conv_clk_ext;
  logic        free_run;
  logic        cs_n;
  logic        wr_n;
  logic        rd_n;
  logic [7:0]  dac_code;
  logic [7:0]  data_out;
  logic [7:0]  vin;
  logic        data_oe;
  logic        conversion_done_n;
  logic [31:0] seed;
  int          error_cnt;
  int          checks_done;

  adcc_ctl #(.INT_DIV(DIV)) uut (.sys_clk(sys_clk), .resetn(resetn), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .comp_in(comp_in), .conv_clk_in(conv_clk_in), .conv_clk_ext(conv_clk_ext), .dac_code(dac_code),
    .data_out(data_out), .data_oe(data_oe), .conversion_done_n(conversion_done_n));
  adcc_host host (.sys_clk(sys_clk), .free_run(free_run), .done_n(conversion_done_n), .cs_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n));

  // Ideal comparator against the analog input code
  assign comp_in = (vin >= dac_code);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    conv_clk_in = 1'b0;
    forever #37 conv_clk_in = ~conv_clk_in;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("mismatches %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (conversion_done_n !== 1'b0 && n < 1500) begin
      @(negedge sys_clk);
      n++;
    end
    check("done low", {7'h00, conversion_done_n}, 8'h00);
  endtask

  // One full conversion followed by a read
  task automatic convert(input logic [7:0] v, input int hold, input bit csf);
    vin = v;
    host.start_conv(hold, csf);
    check("done after start", {7'h00, conversion_done_n}, 8'h01);
    wait_done();
    check("result", data_out, v);
    host.read_bus(1'b1, 4);
    check("enable on read", {7'h00, data_oe}, 8'h01);
    check("read data", data_out, v);
    check("done cleared", {7'h00, conversion_done_n}, 8'h01);
    host.release_bus();
    repeat (3) @(negedge sys_clk);
    check("enable released", {7'h00, data_oe}, 8'h00);
  endtask

  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    results();
  end

  initial begin
    resetn = 1'b0;
    vin = 8'h00;
    conv_clk_ext = 1'b0;
    free_run = 1'b0;
    seed = 32'h92d601d0;
    error_cnt = 0;
    checks_done = 0;
    repeat (3) @(negedge sys_clk);
    check("reset enable", {7'h00, data_oe}, 8'h00);
    check("reset done", {7'h00, conversion_done_n}, 8'h01);
    check("reset latch", data_out, 8'h00);
    repeat (3) @(negedge sys_clk);
    resetn = 1'b1;
    repeat (4) @(negedge sys_clk);
    // Boundary codes, then random codes, hold lengths and release order
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      convert((i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0], 1 + int'(seed[9:8]), seed[10]);
    end
    // Abort in mid-conversion keeps the old result
    convert(8'h5a, 2, 1'b0);
    vin = 8'ha3;
    host.start_conv(2, 1'b0);
    repeat (200) @(negedge sys_clk);
    check("done mid conversion", {7'h00, conversion_done_n}, 8'h01);
    check("latch before abort", data_out, 8'h5a);
    vin = 8'h3c;
    host.start_conv(1, 1'b1);
    repeat (200) @(negedge sys_clk);
    check("latch after abort", data_out, 8'h5a);
    wait_done();
    check("restarted result", data_out, 8'h3c);
    // Polling read after the documented wait, done ignored
    seed = lfsr(seed);
    vin = seed[7:0];
    host.start_conv(2, 1'b0);
    repeat (74 * DIV + 4) @(negedge sys_clk);
    host.read_bus(1'b1, 3);
    check("polled result", data_out, vin);
    host.release_bus();
    // Converter clock from the outside pin
    conv_clk_ext = 1'b1;
    seed = lfsr(seed);
    convert(seed[7:0], 3, 1'b1);
    conv_clk_ext = 1'b0;
    // Read strobe without select leaves the pins released
    host.read_bus(1'b0, 4);
    check("unselected read", {7'h00, data_oe}, 8'h00);
    host.release_bus();
    // Free running loop
    free_run = 1'b1;
    host.kick_loop();
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      vin = seed[7:0];
      wait_done();
      repeat (2) @(negedge sys_clk);
      wait_done();
      check("free run result", data_out, vin);
      check("free run enable", {7'h00, data_oe}, 8'h01);
      repeat (2) @(negedge sys_clk);
    end
    free_run = 1'b0;
    repeat (700) @(negedge sys_clk);
    results();
  end
endmodule // adc_conversion_host_control_test

// [adcc_ctl.sv]
// Converter control and host bus logic
`timescale 1ns/10ps
module adcc_ctl #(
  parameter int unsigned INT_DIV = adcc_pkg::INT_DIV_CYC
) (
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       cs_n,
  input  wire logic       wr_n,
  input  wire logic       rd_n,
  input  wire logic       comp_in,
  input  wire logic       conv_clk_in,
  input  wire logic       conv_clk_ext,
  output logic [7:0]      dac_code,
  output logic [7:0]      data_out,
  output logic            data_oe,
  output logic            conversion_done_n
);
  initial begin
    if (INT_DIV < 2 || INT_DIV > 65535) begin
      $error("INT_DIV out of range");
    end
  end

  adcc_sar_if sar_bus ();

  logic [1:0]  rst_q;
  logic        rst_n;
  logic [5:0]  sync1_q;
  logic [5:0]  sync2_q;
  logic        ext_q;
  logic [15:0] div_q;
  logic        div_tick;
  logic        arm_q;
  logic        req_low;
  logic        start_p;
  logic        read_act;
  logic        done_n_q;
  logic [7:0]  dac_q;

  // Reset release through two flip-flops
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= adcc_pkg::SYNC_RST;
      sync2_q <= adcc_pkg::SYNC_RST;
    end else begin
      sync1_q <= {conv_clk_ext, conv_clk_in, comp_in, rd_n, wr_n, cs_n};
      sync2_q <= sync1_q;
    end
  end

  // Converter clock: outside pin edges or internal divider
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= sync2_q[adcc_pkg::PIN_EXT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 16'h0000;
    end else if (div_q == 16'(INT_DIV - 1)) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign div_tick = div_q == 16'(INT_DIV - 1);

  assign sar_bus.tick = sync2_q[adcc_pkg::PIN_SEL] ? (sync2_q[adcc_pkg::PIN_EXT] && !ext_q) : div_tick;

  // Start strobe: both low arms and holds off, release of either starts
  assign req_low = !sync2_q[adcc_pkg::PIN_CS] && !sync2_q[adcc_pkg::PIN_WR];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_q <= 1'b0;
    end else begin
      arm_q <= req_low;
    end
  end
  assign start_p       = arm_q && !req_low;
  assign sar_bus.start = start_p;
  assign sar_bus.abort = req_low;
  assign sar_bus.comp  = sync2_q[adcc_pkg::PIN_COMP];

  adcc_sar u_sar (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sar     (sar_bus)
  );

  // Done flag; completion wins over a read or start in the same cycle
  assign read_act = !sync2_q[adcc_pkg::PIN_CS] && !sync2_q[adcc_pkg::PIN_RD];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_n_q <= 1'b1;
    end else if (sar_bus.done) begin
      done_n_q <= 1'b0;
    end else if (start_p || req_low || read_act) begin
      done_n_q <= 1'b1;
    end
  end
  assign conversion_done_n = done_n_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_q <= 8'h00;
    end else begin
      dac_q <= sar_bus.trial;
    end
  end
  assign dac_code = dac_q;

  // Three-state data pins show the latch while enabled
  assign data_out = sar_bus.result;
  assign data_oe  = read_act;

  sequence s_arm;
    req_low ##1 !req_low;
  endsequence

  sequence s_finish;
    sar_bus.done ##1 !conversion_done_n;
  endsequence

  property p_release_starts;
    @(posedge sys_clk) disable iff (!rst_n)
      s_arm |-> start_p ##1 (sar_bus.busy && conversion_done_n);
  endproperty
  a_release_starts: assert property (p_release_starts) else $error("Strobe release did not start");

  property p_start_busy;
    @(posedge sys_clk) disable iff (!rst_n)
      start_p |=> sar_bus.busy && dac_code == 8'h00;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("Start did not begin conversion");

  property p_latch_only_on_done;
    @(posedge sys_clk) disable iff (!rst_n)
      !sar_bus.done |-> $stable(data_out);
  endproperty
  a_latch_only_on_done: assert property (p_latch_only_on_done) else $error("Latch moved without completion");

  property p_done_signals;
    @(posedge sys_clk) disable iff (!rst_n)
      $fell(conversion_done_n) |-> $past(sar_bus.done) && data_out == $past(sar_bus.result);
  endproperty
  a_done_signals: assert property (p_done_signals) else $error("Done without fresh result");

  property p_done_holds;
    @(posedge sys_clk) disable iff (!rst_n)
      !conversion_done_n && !start_p && !req_low && !read_act |=> !conversion_done_n;
  endproperty
  a_done_holds: assert property (p_done_holds) else $error("Done dropped without cause");

  property p_read_clears;
    @(posedge sys_clk) disable iff (!rst_n)
      read_act && !sar_bus.done |=> conversion_done_n;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("Read did not clear done");

  property p_oe_follows_pins;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(rst_n, 2) |-> data_oe == (!$past(cs_n, 2) && !$past(rd_n, 2));
  endproperty
  a_oe_follows_pins: assert property (p_oe_follows_pins) else $error("Output enable mismatch");

  property p_oe_shows_latest;
    @(posedge sys_clk) disable iff (!rst_n)
      s_finish ##0 data_oe |-> data_out == $past(sar_bus.result);
  endproperty
  a_oe_shows_latest: assert property (p_oe_shows_latest) else $error("Enabled data not latest");

  property p_int_tick_spacing;
    @(posedge sys_clk) disable iff (!rst_n)
      !sync2_q[adcc_pkg::PIN_SEL] && div_tick |=> !div_tick && div_q == 16'h0000;
  endproperty
  a_int_tick_spacing: assert property (p_int_tick_spacing) else $error("Internal clock spacing wrong");
endmodule // adcc_ctl

// [adcc_host.sv]
// Bus host model driving the converter strobes
`timescale 1ns/10ps
module adcc_host (
  input  wire logic sys_clk,
  input  wire logic free_run,
  input  wire logic done_n,
  output logic      cs_n,
  output logic      wr_n,
  output logic      rd_n
);
  logic cs_q   = 1'b1;
  logic wr_q   = 1'b1;
  logic rd_q   = 1'b1;
  logic kick_q = 1'b0;

  // Select from a decoded address; free running ties select and enable low
  assign cs_n = free_run ? 1'b0 : cs_q;
  assign rd_n = free_run ? 1'b0 : rd_q;
  // Done looped back to start, forced low briefly to get the loop going
  assign wr_n = free_run ? (done_n & ~kick_q) : wr_q;

  // Write pulse; released either by select or by start first
  task automatic start_conv(input int hold, input bit cs_first);
    @(negedge sys_clk);
    cs_q = 1'b0;
    wr_q = 1'b0;
    repeat (hold) @(negedge sys_clk);
    if (cs_first) begin
      cs_q = 1'b1;
    end else begin
      wr_q = 1'b1;
    end
    @(negedge sys_clk);
    cs_q = 1'b1;
    wr_q = 1'b1;
  endtask

  // Read pulse, with or without select
  task automatic read_bus(input bit sel, input int hold);
    @(negedge sys_clk);
    cs_q = ~sel;
    rd_q = 1'b0;
    repeat (hold) @(negedge sys_clk);
  endtask

  task automatic release_bus();
    cs_q = 1'b1;
    rd_q = 1'b1;
    @(negedge sys_clk);
  endtask

  // Pulls the looped node low after power-up
  task automatic kick_loop();
    @(negedge sys_clk);
    kick_q = 1'b1;
    repeat (3) @(negedge sys_clk);
    kick_q = 1'b0;
  endtask
endmodule // adcc_host

// [adcc_pkg.sv]
// Constants and types shared by the converter control block
package adcc_pkg;
  localparam int unsigned RES_BITS         = 8;
  localparam int unsigned SYS_PERIOD_NS    = 25;
  localparam int unsigned INT_CLK_PERIOD_NS = 1000;
  localparam int unsigned INT_DIV_CYC      = (INT_CLK_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned SETTLE_TICKS     = 8;
  localparam int unsigned BIT_TICKS        = 8;
  localparam int unsigned HOST_WAIT_TICKS  = 74;
  localparam logic [7:0]  RESULT_RST       = 8'h00;
  localparam logic [5:0]  SYNC_RST         = 6'h07;
  localparam int unsigned PIN_CS           = 0;
  localparam int unsigned PIN_WR           = 1;
  localparam int unsigned PIN_RD           = 2;
  localparam int unsigned PIN_COMP         = 3;
  localparam int unsigned PIN_EXT          = 4;
  localparam int unsigned PIN_SEL          = 5;

  typedef enum logic [1:0] {
    ADCC_IDLE   = 2'b00,
    ADCC_SETTLE = 2'b01,
    ADCC_BITS   = 2'b10
  } adcc_state_e;
endpackage

// [adcc_sar.sv]
// Successive approximation engine
`timescale 1ns/10ps
module adcc_sar (
  input wire logic sys_clk,
  input wire logic rst_n,
  adcc_sar_if.sar  sar
);
  adcc_pkg::adcc_state_e state_q;
  logic [2:0]            cnt_q;
  logic [2:0]            bit_q;
  logic [7:0]            code_q;
  logic [7:0]            result_q;
  logic                  done_q;
  logic                  last_tick;

  function automatic logic [7:0] adcc_onehot(input logic [2:0] idx);
    adcc_onehot = 8'h01 << idx;
  endfunction

  assign last_tick = sar.tick && (state_q == adcc_pkg::ADCC_SETTLE ?
                     cnt_q == 3'(adcc_pkg::SETTLE_TICKS - 1) : cnt_q == 3'(adcc_pkg::BIT_TICKS - 1));

  // Sequencing; abort and start override a running conversion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= adcc_pkg::ADCC_IDLE;
    end else if (sar.abort) begin
      state_q <= adcc_pkg::ADCC_IDLE;
    end else if (sar.start) begin
      state_q <= adcc_pkg::ADCC_SETTLE;
    end else if (last_tick) begin
      case (state_q)
        adcc_pkg::ADCC_SETTLE: state_q <= adcc_pkg::ADCC_BITS;
        adcc_pkg::ADCC_BITS: begin
          if (bit_q == 3'h0) begin
            state_q <= adcc_pkg::ADCC_IDLE;
          end
        end
        default: state_q <= adcc_pkg::ADCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
    end else if (sar.abort || sar.start || last_tick) begin
      cnt_q <= 3'h0;
    end else if (sar.tick) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Bits resolved from the top down give a straight binary code
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_q  <= 3'h7;
      code_q <= 8'h00;
    end else if (sar.abort || sar.start) begin
      bit_q  <= 3'h7;
      code_q <= 8'h00;
    end else if (last_tick && state_q == adcc_pkg::ADCC_BITS) begin
      if (sar.comp) begin
        code_q <= code_q | adcc_onehot(bit_q);
      end
      bit_q <= bit_q - 3'h1;
    end
  end

  // Result only updates on a finished conversion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= adcc_pkg::RESULT_RST;
      done_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!sar.abort && !sar.start && last_tick && state_q == adcc_pkg::ADCC_BITS && bit_q == 3'h0) begin
        result_q <= sar.comp ? (code_q | 8'h01) : code_q;
        done_q   <= 1'b1;
      end
    end
  end

  assign sar.busy   = state_q != adcc_pkg::ADCC_IDLE;
  assign sar.done   = done_q;
  assign sar.result = result_q;
  assign sar.trial  = state_q == adcc_pkg::ADCC_BITS ? (code_q | adcc_onehot(bit_q)) : code_q;

  property p_lower_bits_clear;
    @(posedge sys_clk) disable iff (!rst_n)
      state_q == adcc_pkg::ADCC_BITS |-> (code_q & ((adcc_onehot(bit_q) << 1) - 8'h01)) == 8'h00;
  endproperty
  a_lower_bits_clear: assert property (p_lower_bits_clear) else $error("Unresolved bits not clear");

  property p_abort_idles;
    @(posedge sys_clk) disable iff (!rst_n)
      sar.abort |=> !sar.busy && !done_q;
  endproperty
  a_abort_idles: assert property (p_abort_idles) else $error("Abort did not stop conversion");
endmodule // adcc_sar

// [adcc_sar_if.sv]
// Signals between the control logic and the approximation engine
`timescale 1ns/10ps
interface adcc_sar_if;
  logic       tick;
  logic       start;
  logic       abort;
  logic       comp;
  logic       busy;
  logic       done;
  logic [7:0] trial;
  logic [7:0] result;

  modport sar (input tick, input start, input abort, input comp,
               output busy, output done, output trial, output result);
  modport ctl (output tick, output start, output abort, output comp,
               input busy, input done, input trial, input result);
endinterface
